// *** src/dag_data_path.sv ***
// Data address generator, pointer pairs and arithmetic flag register
`timescale 1ns/100ps

// Behaviour
// - Flag bits seven to five read zero
// - Negative flag copies result bit seven
// - Overflow flag marks signed overflow
// - Zero flag set on all-zero result
// - Add/sub: half carry from bit three
// - Add/sub: carry out of bit seven
// - Subtract adds two's complement of W
// - Rotate through carry loads shifted-out bit
// - Access select one: bank register plus field
// - Access select zero: fixed access bank
// - Full address operands ignore bank register
// - Destination bit picks file or W
// - Three twelve-bit pointer pairs, high nibble unused
// - Plain indirect uses pointer, pointer unchanged
// - Indirect ignores bank and access select
// - Post inc/dec after, pre-increment before access
// - Pointer plus signed W, nothing modified
// - Pointer steps carry across both bytes
// - Pointer steps never touch flags
// - Indirect onto virtual operand: read zero, no write
// - Write onto pointer pair skips auto step
// - Indexed offset mode only when extension enabled
// - Extended, access zero, field<=5Fh: third pointer plus field
// - Flag-affecting op onto flags: flags win
module dag_data_path (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Operation from the instruction decoder
  input wire logic op_valid_i,
  input wire dag_pkg::dag_op_t op_i,
  input wire logic [7:0] w_i,
  output logic op_ready_o,
  output logic done_o,
  // Working register write back
  output logic w_wr_o,
  output logic [7:0] w_wdata_o,
  // Data memory
  output dag_pkg::dag_mem_req_t mem_req_o,
  input wire logic [7:0] mem_rdata_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dag_pkg::dag_state_t state_ff;
  dag_pkg::dag_op_t op_ff;
  dag_pkg::dag_vkind_t vkind_ff;
  dag_pkg::dag_mem_req_t mem_req_ff;
  logic [1:0] vidx_ff;
  logic [11:0] addr_ff;
  logic tgt_virt_ff;
  logic [7:0] w_ff;
  logic [4:0] flags_ff;
  logic [3:0] bsr_ff;
  logic [11:0] ptr_ff [3];
  logic ext_en_ff;
  logic w_wr_ff;
  logic [7:0] w_wdata_ff;
  logic done_ff;
  logic [7:0] reg_rdata_ff;

  // Returns {kind, pointer index} for a data address
  function automatic logic [4:0] vdecode(input logic [11:0] a);
    logic [11:0] ofs;
    logic [4:0] r;
    r = {dag_pkg::VK_NONE, 2'd0};
    for (int n = 0; n < 3; n++) begin
      ofs = dag_pkg::ADR_IND_BASE[n] - a;
      if (ofs == 12'h000) begin
        r = {dag_pkg::VK_PLAIN, 2'(n)};
      end else if (ofs == dag_pkg::VOFS_POST_INCREMENT_OPERAND) begin
        r = {dag_pkg::VK_POST_INCREMENT_OPERAND, 2'(n)};
      end else if (ofs == dag_pkg::VOFS_POST_DECREMENT_OPERAND) begin
        r = {dag_pkg::VK_POST_DECREMENT_OPERAND, 2'(n)};
      end else if (ofs == dag_pkg::VOFS_PRE_INCREMENT_OPERAND) begin
        r = {dag_pkg::VK_PRE_INCREMENT_OPERAND, 2'(n)};
      end else if (ofs == dag_pkg::VOFS_POINTER_OFFSET_BY_W_OPERAND) begin
        r = {dag_pkg::VK_POINTER_OFFSET_BY_W_OPERAND, 2'(n)};
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Address resolution while idle
  // ---------------------------------------------------------------
  logic accept;
  logic [11:0] dir_addr;
  logic [11:0] eff_addr;
  logic [4:0] dir_dec;
  logic [4:0] eff_dec;
  dag_pkg::dag_vkind_t dir_kind;
  logic [1:0] dir_idx;
  logic eff_virt;
  logic eff_internal;

  assign accept = op_valid_i && (state_ff == dag_pkg::ST_IDLE);
  assign op_ready_o = (state_ff == dag_pkg::ST_IDLE);

  always_comb begin
    if (op_i.full_addr_use) begin
      dir_addr = op_i.full_addr;
    end else if (op_i.access_sel) begin
      dir_addr = {bsr_ff, op_i.field};
    end else if (ext_en_ff && (op_i.field <= dag_pkg::EXT_OFFSET_MAX)) begin
      dir_addr = ptr_ff[2] + {4'h0, op_i.field};
    end else if (op_i.field >= dag_pkg::ACCESS_SPLIT) begin
      dir_addr = {dag_pkg::ACCESS_HI_BANK, op_i.field};
    end else begin
      dir_addr = {dag_pkg::ACCESS_LO_BANK, op_i.field};
    end
  end

  assign dir_dec = vdecode(dir_addr);
  assign dir_kind = dag_pkg::dag_vkind_t'(dir_dec[4:2]);
  assign dir_idx = dir_dec[1:0];

  // Indirect targets come only from the pointer, never from bank or access bit
  always_comb begin
    case (dir_kind)
      dag_pkg::VK_PLAIN, dag_pkg::VK_POST_INCREMENT_OPERAND, dag_pkg::VK_POST_DECREMENT_OPERAND: begin
        eff_addr = ptr_ff[dir_idx];
      end
      dag_pkg::VK_PRE_INCREMENT_OPERAND: begin
        eff_addr = ptr_ff[dir_idx] + dag_pkg::PTR_STEP;
      end
      dag_pkg::VK_POINTER_OFFSET_BY_W_OPERAND: begin
        // W is taken as signed; the sum wraps within the data space
        eff_addr = ptr_ff[dir_idx] + {{4{w_i[7]}}, w_i};
      end
      default: begin
        eff_addr = dir_addr;
      end
    endcase
  end

  assign eff_dec = vdecode(eff_addr);
  assign eff_virt = (dir_kind != dag_pkg::VK_NONE) &&
                    (dag_pkg::dag_vkind_t'(eff_dec[4:2]) != dag_pkg::VK_NONE);

  always_comb begin
    eff_internal = (eff_addr == dag_pkg::ADR_FLAGS) || (eff_addr == dag_pkg::ADR_BSR);
    for (int n = 0; n < 3; n++) begin
      if ((eff_addr == dag_pkg::ADR_PTR_LO[n]) || (eff_addr == dag_pkg::ADR_PTR_HI[n])) begin
        eff_internal = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= dag_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        dag_pkg::ST_IDLE: begin
          if (accept) begin
            state_ff <= dag_pkg::ST_READ;
          end
        end
        dag_pkg::ST_READ: state_ff <= dag_pkg::ST_EXEC;
        dag_pkg::ST_EXEC: state_ff <= dag_pkg::ST_FINISH;
        default: state_ff <= dag_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_ff <= '0;
      vkind_ff <= dag_pkg::VK_NONE;
      vidx_ff <= 2'h0;
      addr_ff <= 12'h000;
      tgt_virt_ff <= 1'b0;
      w_ff <= 8'h00;
    end else if (accept) begin
      op_ff <= op_i;
      vkind_ff <= dir_kind;
      vidx_ff <= dir_idx;
      addr_ff <= eff_addr;
      tgt_virt_ff <= eff_virt;
      w_ff <= w_i;
    end
  end

  // ---------------------------------------------------------------
  // Operand fetch and ALU
  // ---------------------------------------------------------------
  logic [7:0] operand;
  logic [7:0] res;
  logic [7:0] b_eff;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic cin;
  logic [4:0] fl_mask;
  logic [4:0] fl_new;
  logic [4:0] flags_nxt;
  logic is_sub;
  logic to_file;
  logic core_wr;

  always_comb begin
    operand = mem_rdata_i;
    if (tgt_virt_ff) begin
      operand = 8'h00;
    end else if (addr_ff == dag_pkg::ADR_FLAGS) begin
      operand = {3'b000, flags_ff};
    end else if (addr_ff == dag_pkg::ADR_BSR) begin
      operand = {4'h0, bsr_ff};
    end
    for (int n = 0; n < 3; n++) begin
      if (addr_ff == dag_pkg::ADR_PTR_LO[n]) begin
        operand = ptr_ff[n][7:0];
      end else if (addr_ff == dag_pkg::ADR_PTR_HI[n]) begin
        operand = {4'h0, ptr_ff[n][11:8]};
      end
    end
  end

  // Subtraction is operand minus W, done as an add of the complement
  assign is_sub = (op_ff.alu_op == dag_pkg::ALU_SUB);
  assign b_eff = is_sub ? ~w_ff : w_ff;
  assign cin = is_sub;
  assign sum9 = {1'b0, operand} + {1'b0, b_eff} + {8'h00, cin};
  assign half5 = {1'b0, operand[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};

  always_comb begin
    res = operand;
    fl_mask = dag_pkg::FLG_MASK_NZ;
    fl_new = flags_ff;
    case (op_ff.alu_op)
      dag_pkg::ALU_MOVWF: begin
        res = w_ff;
        fl_mask = dag_pkg::FLG_MASK_NONE;
      end
      dag_pkg::ALU_CLR: begin
        res = 8'h00;
        fl_mask = dag_pkg::FLG_MASK_Z;
      end
      dag_pkg::ALU_ADD, dag_pkg::ALU_SUB: begin
        res = sum9[7:0];
        fl_mask = dag_pkg::FLG_MASK_ALL;
        fl_new[dag_pkg::FLG_C] = sum9[8];
        fl_new[dag_pkg::FLG_DC] = half5[4];
        fl_new[dag_pkg::FLG_OV] = (operand[7] == b_eff[7]) && (sum9[7] != operand[7]);
      end
      dag_pkg::ALU_AND: res = operand & w_ff;
      dag_pkg::ALU_IOR: res = operand | w_ff;
      dag_pkg::ALU_XOR: res = operand ^ w_ff;
      dag_pkg::ALU_RRC: begin
        res = {flags_ff[dag_pkg::FLG_C], operand[7:1]};
        fl_mask = dag_pkg::FLG_MASK_NZC;
        fl_new[dag_pkg::FLG_C] = operand[0];
      end
      dag_pkg::ALU_RLC: begin
        res = {operand[6:0], flags_ff[dag_pkg::FLG_C]};
        fl_mask = dag_pkg::FLG_MASK_NZC;
        fl_new[dag_pkg::FLG_C] = operand[7];
      end
      default: res = operand;
    endcase
    fl_new[dag_pkg::FLG_N] = res[7];
    fl_new[dag_pkg::FLG_Z] = (res == 8'h00);
    flags_nxt = (fl_new & fl_mask) | (flags_ff & ~fl_mask);
  end

  // Moves of W and clears always land in the file register
  assign to_file = op_ff.dest_sel || (op_ff.alu_op == dag_pkg::ALU_MOVWF) ||
                   (op_ff.alu_op == dag_pkg::ALU_CLR);
  assign core_wr = (state_ff == dag_pkg::ST_EXEC) && to_file && !tgt_virt_ff;

  // ---------------------------------------------------------------
  // Flags, bank select and configuration
  // ---------------------------------------------------------------
  // Only ALU results and register port writes reach the flags; pointer steps have no path here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_ff <= dag_pkg::FLAGS_RST;
    end else if ((state_ff == dag_pkg::ST_EXEC) && (fl_mask != dag_pkg::FLG_MASK_NONE)) begin
      flags_ff <= flags_nxt;
    end else if (core_wr && (addr_ff == dag_pkg::ADR_FLAGS)) begin
      flags_ff <= res[4:0];
    end else if (reg_wr_i && (reg_addr_i == dag_pkg::REG_FLAGS)) begin
      flags_ff <= reg_wdata_i[4:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bsr_ff <= dag_pkg::BSR_RST;
    end else if (core_wr && (addr_ff == dag_pkg::ADR_BSR)) begin
      bsr_ff <= res[3:0];
    end else if (reg_wr_i && (reg_addr_i == dag_pkg::REG_BSR)) begin
      bsr_ff <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_en_ff <= dag_pkg::CFG_EXT_RST;
    end else if (reg_wr_i && (reg_addr_i == dag_pkg::REG_CONFIG)) begin
      ext_en_ff <= reg_wdata_i[0];
    end
  end

  // ---------------------------------------------------------------
  // Pointer pairs
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ptr
      logic hit_lo;
      logic hit_hi;
      logic own_step;
      logic [3:0] bus_lo_idx;
      logic [3:0] bus_hi_idx;

      assign hit_lo = core_wr && (addr_ff == dag_pkg::ADR_PTR_LO[g]);
      assign hit_hi = core_wr && (addr_ff == dag_pkg::ADR_PTR_HI[g]);
      assign own_step = (state_ff == dag_pkg::ST_EXEC) && (vidx_ff == 2'(g));
      assign bus_lo_idx = dag_pkg::REG_PTR0_LO + 4'(2 * g);
      assign bus_hi_idx = bus_lo_idx + 4'h1;

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ptr_ff[g] <= dag_pkg::PTR_RST;
        end else if (hit_lo) begin
          ptr_ff[g][7:0] <= res;
        end else if (hit_hi) begin
          ptr_ff[g][11:8] <= res[3:0];
        end else if (own_step && ((vkind_ff == dag_pkg::VK_POST_INCREMENT_OPERAND) ||
                                  (vkind_ff == dag_pkg::VK_PRE_INCREMENT_OPERAND))) begin
          ptr_ff[g] <= ptr_ff[g] + dag_pkg::PTR_STEP;
        end else if (own_step && (vkind_ff == dag_pkg::VK_POST_DECREMENT_OPERAND)) begin
          ptr_ff[g] <= ptr_ff[g] - dag_pkg::PTR_STEP;
        end else if (reg_wr_i && (reg_addr_i == bus_lo_idx)) begin
          ptr_ff[g][7:0] <= reg_wdata_i;
        end else if (reg_wr_i && (reg_addr_i == bus_hi_idx)) begin
          ptr_ff[g][11:8] <= reg_wdata_i[3:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Memory, W and completion outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_req_ff <= '0;
    end else begin
      mem_req_ff.rd <= accept && !eff_internal && !eff_virt;
      mem_req_ff.wr <= 1'b0;
      if (accept) begin
        mem_req_ff.addr <= eff_addr;
      end
      if (core_wr && !(addr_ff == dag_pkg::ADR_FLAGS) && !(addr_ff == dag_pkg::ADR_BSR) &&
          !g_ptr[0].hit_lo && !g_ptr[0].hit_hi && !g_ptr[1].hit_lo &&
          !g_ptr[1].hit_hi && !g_ptr[2].hit_lo && !g_ptr[2].hit_hi) begin
        mem_req_ff.wr <= 1'b1;
        mem_req_ff.wdata <= res;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_wr_ff <= 1'b0;
      w_wdata_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      w_wr_ff <= (state_ff == dag_pkg::ST_EXEC) && !to_file;
      done_ff <= (state_ff == dag_pkg::ST_EXEC);
      if ((state_ff == dag_pkg::ST_EXEC) && !to_file) begin
        w_wdata_ff <= res;
      end
    end
  end

  assign mem_req_o = mem_req_ff;
  assign w_wr_o = w_wr_ff;
  assign w_wdata_o = w_wdata_ff;
  assign done_o = done_ff;

  // ---------------------------------------------------------------
  // Register port read
  // ---------------------------------------------------------------
  logic [7:0] reg_mux;

  always_comb begin
    reg_mux = 8'h00;
    if (reg_addr_i == dag_pkg::REG_FLAGS) begin
      reg_mux = {3'b000, flags_ff};
    end else if (reg_addr_i == dag_pkg::REG_BSR) begin
      reg_mux = {4'h0, bsr_ff};
    end else if (reg_addr_i == dag_pkg::REG_CONFIG) begin
      reg_mux = {7'h00, ext_en_ff};
    end else if (reg_addr_i == dag_pkg::REG_STATE) begin
      reg_mux = {6'h00, tgt_virt_ff, state_ff != dag_pkg::ST_IDLE};
    end else if ((reg_addr_i >= dag_pkg::REG_PTR0_LO) && (reg_addr_i < dag_pkg::REG_CONFIG)) begin
      for (int n = 0; n < 3; n++) begin
        if (reg_addr_i == dag_pkg::REG_PTR0_LO + 4'(2 * n)) begin
          reg_mux = ptr_ff[n][7:0];
        end else if (reg_addr_i == dag_pkg::REG_PTR0_LO + 4'(2 * n + 1)) begin
          reg_mux = {4'h0, ptr_ff[n][11:8]};
        end
      end
    end
  end

  // Read data stand for one cycle only; idle cycles read as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= reg_rd_i ? reg_mux : 8'h00;
    end
  end

  assign reg_rdata_o = reg_rdata_ff;

endmodule

// *** src/dag_pkg.sv ***
// Package of constants and types for the data address generator and flags slice
package dag_pkg;

  // ---------------------------------------------------------------
  // Flag register layout
  // ---------------------------------------------------------------
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_DC = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned FLG_N = 4;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [4:0] FLG_MASK_NONE = 5'h00;
  localparam logic [4:0] FLG_MASK_ALL = 5'h1F;
  localparam logic [4:0] FLG_MASK_NZ = 5'h14;
  localparam logic [4:0] FLG_MASK_Z = 5'h04;
  localparam logic [4:0] FLG_MASK_NZC = 5'h15;

  // ---------------------------------------------------------------
  // Direct addressing
  // ---------------------------------------------------------------
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] EXT_OFFSET_MAX = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  // ---------------------------------------------------------------
  // Data space addresses of the slice's own registers
  // ---------------------------------------------------------------
  localparam logic [11:0] ADR_FLAGS = 12'hFD8;
  localparam logic [11:0] ADR_BSR = 12'hFE0;
  localparam logic [2:0][11:0] ADR_PTR_LO = {12'hFD9, 12'hFE1, 12'hFE9};
  localparam logic [2:0][11:0] ADR_PTR_HI = {12'hFDA, 12'hFE2, 12'hFEA};
  localparam logic [2:0][11:0] ADR_IND_BASE = {12'hFDF, 12'hFE7, 12'hFEF};
  // Virtual operands sit just below the plain operand address
  localparam logic [11:0] VOFS_POST_INCREMENT_OPERAND = 12'h001;
  localparam logic [11:0] VOFS_POST_DECREMENT_OPERAND = 12'h002;
  localparam logic [11:0] VOFS_PRE_INCREMENT_OPERAND = 12'h003;
  localparam logic [11:0] VOFS_POINTER_OFFSET_BY_W_OPERAND = 12'h004;
  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic [11:0] PTR_STEP = 12'h001;
  localparam logic [3:0] BSR_RST = 4'h0;

  // ---------------------------------------------------------------
  // Register port map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_FLAGS = 4'h0;
  localparam logic [3:0] REG_BSR = 4'h1;
  localparam logic [3:0] REG_PTR0_LO = 4'h2;
  localparam logic [3:0] REG_CONFIG = 4'h8;
  localparam logic [3:0] REG_STATE = 4'h9;
  localparam logic CFG_EXT_RST = 1'b0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ALU_MOVF, ALU_MOVWF, ALU_CLR, ALU_ADD, ALU_SUB,
    ALU_AND, ALU_IOR, ALU_XOR, ALU_RRC, ALU_RLC
  } dag_alu_t;

  typedef enum logic [2:0] {
    VK_NONE, VK_PLAIN, VK_POST_INCREMENT_OPERAND, VK_POST_DECREMENT_OPERAND, VK_PRE_INCREMENT_OPERAND, VK_POINTER_OFFSET_BY_W_OPERAND
  } dag_vkind_t;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_FINISH} dag_state_t;

  typedef struct packed {
    dag_alu_t alu_op;
    logic full_addr_use;
    logic access_sel;
    logic dest_sel;
    logic [7:0] field;
    logic [11:0] full_addr;
  } dag_op_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dag_mem_req_t;

endpackage

// *** verification/dag_data_path_checker.sv ***
// Port checker for the data address generator and flag register
`timescale 1ns/100ps
module dag_data_path_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Operation port
  input wire logic op_valid_i,
  input wire dag_pkg::dag_op_t op_i,
  input wire logic op_ready_o,
  input wire logic done_o,
  input wire logic w_wr_o,
  input wire dag_pkg::dag_mem_req_t mem_req_o,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Bank shadow follows port writes only; bench never writes it from the core
  logic [3:0] bsr_sh_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bsr_sh_ff <= dag_pkg::BSR_RST;
    end else if (reg_wr_i && reg_addr_i == dag_pkg::REG_BSR) begin
      bsr_sh_ff <= reg_wdata_i[3:0];
    end
  end
  sequence s_accept;
    op_valid_i && op_ready_o;
  endsequence
  sequence s_mem_full;
    s_accept ##0 (op_i.full_addr_use && op_i.full_addr[11:8] != 4'hF);
  endsequence
  property p_flags_top;
    reg_rd_i && reg_addr_i == dag_pkg::REG_FLAGS |=> reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_flags_top: assert property (p_flags_top) else $error("flag top bits not zero");
  property p_ptr_hi_top;
    reg_rd_i && reg_addr_i inside {4'h3, 4'h5, 4'h7} |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_ptr_hi_top: assert property (p_ptr_hi_top) else $error("pointer high nibble");
  property p_bank_direct;
    s_accept ##0 (!op_i.full_addr_use && op_i.access_sel && bsr_sh_ff != 4'hF)
      |=> mem_req_o.addr == {$past(bsr_sh_ff), $past(op_i.field)};
  endproperty
  a_bank_direct: assert property (p_bank_direct) else $error("banked address");
  property p_access_hi;
    s_accept ##0 (!op_i.full_addr_use && !op_i.access_sel && op_i.field >= 8'h60
      && op_i.field < 8'hD8) |=> mem_req_o.addr == {4'hF, $past(op_i.field)};
  endproperty
  a_access_hi: assert property (p_access_hi) else $error("access bank address");
  property p_full_addr;
    s_mem_full |=> mem_req_o.addr == $past(op_i.full_addr);
  endproperty
  a_full_addr: assert property (p_full_addr) else $error("full address");
  property p_dest_file;
    s_mem_full ##0 (op_i.dest_sel || op_i.alu_op == dag_pkg::ALU_MOVWF)
      |-> ##3 (done_o && mem_req_o.wr && !w_wr_o);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file write missing");
  property p_dest_w;
    s_accept ##0 (!op_i.dest_sel && op_i.alu_op != dag_pkg::ALU_MOVWF
      && op_i.alu_op != dag_pkg::ALU_CLR) |-> ##3 (done_o && w_wr_o && !mem_req_o.wr);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("W write missing");
  property p_op_cycle;
    s_accept |=> !op_ready_o [*3] ##1 op_ready_o;
  endproperty
  a_op_cycle: assert property (p_op_cycle) else $error("operation length");
endmodule
bind dag_data_path dag_data_path_checker i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .op_valid_i(op_valid_i), .op_i(op_i), .op_ready_o(op_ready_o), .done_o(done_o),
  .w_wr_o(w_wr_o), .mem_req_o(mem_req_o), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o));

// *** verification/dag_data_path_tb.sv ***
// Self-checking bench for the data address generator and flag register
`timescale 1ns/100ps
module dag_data_path_tb;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  dag_pkg::dag_op_t op_i = '0;
  logic [7:0] w_i = 8'h00;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic op_ready_o, done_o, w_wr_o;
  logic [7:0] w_wdata_o, mem_rdata_i, reg_rdata_o;
  dag_pkg::dag_mem_req_t mem_req_o;
  int mismatches = 0;
  int comparisons = 0;
  dag_data_path i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .w_i(w_i), .op_ready_o(op_ready_o), .done_o(done_o), .w_wr_o(w_wr_o), .w_wdata_o(w_wdata_o),
    .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  dag_mem_model i_mem (.clk_i(clk_i), .req_i(mem_req_o), .rdata_o(mem_rdata_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // Memory pattern depends on the bank too, so a wrong bank reads a wrong byte
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  // Mode m is {full address, access select, destination}
  task automatic op(input dag_pkg::dag_alu_t alu, input logic [2:0] m, input logic [11:0] adr,
                    input logic [7:0] w, input logic [7:0] exp);
    int n;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= '{alu, m[2], m[1], m[0], adr[7:0], adr};
    w_i <= w;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    for (n = 0; n < 8 && done_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (done_o !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t operation timed out", $time);
      print_verdict();
    end else begin
      if (!m[0] && alu != dag_pkg::ALU_MOVWF) begin
        chk(w_wdata_o, exp);
      end
      @(posedge clk_i);
      #1;
    end
  endtask
  initial begin
    for (int i = 0; i < 4096; i++) begin
      i_mem.mem[i] = pat(i[11:0]);
    end
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(dag_pkg::REG_FLAGS, 8'h00);
    wr(4'hA, 8'hFF);
    rd(4'hA, 8'h00);
    op(dag_pkg::ALU_ADD, 3'b100, 12'h07F, 8'h01, 8'h80);
    rd(dag_pkg::REG_FLAGS, 8'h1A);
    op(dag_pkg::ALU_ADD, 3'b101, 12'h0FF, 8'h01, 8'h00);
    chk(i_mem.mem[12'h0FF], 8'h00);
    rd(dag_pkg::REG_FLAGS, 8'h07);
    op(dag_pkg::ALU_SUB, 3'b100, 12'h005, 8'h06, 8'hFF);
    rd(dag_pkg::REG_FLAGS, 8'h10);
    op(dag_pkg::ALU_SUB, 3'b100, 12'h006, 8'h06, 8'h00);
    rd(dag_pkg::REG_FLAGS, 8'h07);
    wr(dag_pkg::REG_FLAGS, 8'h01);
    op(dag_pkg::ALU_RRC, 3'b100, 12'h002, 8'h00, 8'h81);
    rd(dag_pkg::REG_FLAGS, 8'h10);
    op(dag_pkg::ALU_RLC, 3'b100, 12'h080, 8'h00, 8'h00);
    rd(dag_pkg::REG_FLAGS, 8'h05);
    wr(dag_pkg::REG_BSR, 8'h03);
    op(dag_pkg::ALU_MOVF, 3'b010, 12'h044, 8'h00, pat(12'h344));
    op(dag_pkg::ALU_MOVF, 3'b000, 12'h044, 8'h00, pat(12'h044));
    op(dag_pkg::ALU_MOVF, 3'b000, 12'h0A0, 8'h00, pat(12'hFA0));
    op(dag_pkg::ALU_MOVF, 3'b110, 12'h7AB, 8'h00, pat(12'h7AB));
    wr(4'h2, 8'hFF);
    wr(4'h3, 8'h01);
    wr(dag_pkg::REG_BSR, 8'h0F);
    op(dag_pkg::ALU_MOVF, 3'b010, 12'hFEF, 8'h00, pat(12'h1FF));
    rd(4'h2, 8'hFF);
    wr(dag_pkg::REG_FLAGS, 8'h0B);
    op(dag_pkg::ALU_MOVWF, 3'b100, 12'hFEE, 8'h33, 8'h00);
    chk(i_mem.mem[12'h1FF], 8'h33);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h02);
    rd(dag_pkg::REG_FLAGS, 8'h0B);
    op(dag_pkg::ALU_MOVWF, 3'b100, 12'hFED, 8'h44, 8'h00);
    chk(i_mem.mem[12'h200], 8'h44);
    rd(4'h3, 8'h01);
    op(dag_pkg::ALU_MOVWF, 3'b100, 12'hFEC, 8'h55, 8'h00);
    chk(i_mem.mem[12'h200], 8'h55);
    op(dag_pkg::ALU_MOVF, 3'b100, 12'hFEB, 8'hFF, 8'h33);
    rd(4'h2, 8'h00);
    wr(4'h2, 8'hE7);
    wr(4'h3, 8'h0F);
    op(dag_pkg::ALU_MOVF, 3'b100, 12'hFEF, 8'h00, 8'h00);
    op(dag_pkg::ALU_MOVWF, 3'b100, 12'hFEF, 8'h99, 8'h00);
    chk(i_mem.mem[12'hFE7], pat(12'hFE7));
    rd(dag_pkg::REG_STATE, 8'h02);
    wr(4'h6, 8'hD9);
    wr(4'h7, 8'h0F);
    op(dag_pkg::ALU_MOVWF, 3'b100, 12'hFDD, 8'h77, 8'h00);
    rd(4'h6, 8'h77);
    wr(4'h6, 8'h10);
    wr(4'h7, 8'h03);
    op(dag_pkg::ALU_MOVF, 3'b000, 12'h010, 8'h00, pat(12'h010));
    wr(dag_pkg::REG_CONFIG, 8'h01);
    op(dag_pkg::ALU_MOVF, 3'b000, 12'h010, 8'h00, pat(12'h320));
    op(dag_pkg::ALU_MOVF, 3'b000, 12'h05F, 8'h00, pat(12'h36F));
    op(dag_pkg::ALU_MOVF, 3'b000, 12'h060, 8'h00, pat(12'hF60));
    wr(dag_pkg::REG_FLAGS, 8'h00);
    op(dag_pkg::ALU_ADD, 3'b101, 12'hFD8, 8'h80, 8'h00);
    rd(dag_pkg::REG_FLAGS, 8'h10);
    op(dag_pkg::ALU_CLR, 3'b101, 12'hFD8, 8'h00, 8'h00);
    rd(dag_pkg::REG_FLAGS, 8'h14);
    op(dag_pkg::ALU_XOR, 3'b100, 12'h044, 8'h44, 8'h00);
    rd(dag_pkg::REG_FLAGS, 8'h04);
    op(dag_pkg::ALU_IOR, 3'b100, 12'h044, 8'h80, 8'hC4);
    op(dag_pkg::ALU_AND, 3'b100, 12'h044, 8'h0F, 8'h04);
    rd(dag_pkg::REG_FLAGS, 8'h00);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h0F);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(4'h3, 8'h00);
    print_verdict();
  end
endmodule

// *** verification/dag_mem_model.sv ***
// Byte-wide data memory model for the data path's memory port
`timescale 1ns/100ps
module dag_mem_model (
  // Clock and request
  input wire logic clk_i,
  input wire dag_pkg::dag_mem_req_t req_i,
  // Read data
  output logic [7:0] rdata_o
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem [0:4095];
  initial rdata_o = 8'h00;
  // Outside a read answer the lines flip, so stale data never passes
  always @(posedge clk_i) begin
    if (req_i.wr) begin
      mem[req_i.addr] <= req_i.wdata;
    end
    if (req_i.rd) begin
      rdata_o <= mem[req_i.addr];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule
